// >>> hw/sact_ctrl.v
// SAR converter channel, clock and trigger control with AXI4-Lite slave
// Behaviour
// RL1: decode channel code; pins gated; 11111 off
// RL2: reserved codes give undefined result
// RL3: code 11010 selects temperature sensor
// RL4: software enables bandgap buffer before 11011
// RL5: conversion clock: bus, half bus, async
// RL6: hardware trigger on wakeup counter overflow
// RL7: wakeup counter clock: reference or 1 kHz
// RL8: triggers in run, wait and stop3
// RL9: stop3 converting needs both low-voltage enables
// RL10: one analog pin enable register
// RL11: linear successive approximation, 10-bit result
// RL12: right-justified 10-bit or 8-bit result
// RL13: single or continuous; single returns idle
// RL14: complete flag with maskable interrupt
// RL15: optional compare, less-than or greater-equal
// RL16: configurable sample time and speed/power
// RL17: hardware trigger selectable over software start
// RL18: control-1 write aborts, restarts unless off
// RL19: flag set per compare; cleared write/read
// RL20: continuous with hardware trigger starts on trigger
// RL21: interrupt when flag set with enable
`include "sact_regs.vh"
`timescale 1ns/1ns
`default_nettype none
module sact_ctrl #(
  parameter KHZ_DIV = `SACT_CLK_HZ / `SACT_KHZ_HZ
) (
  input wire sys_clk,
  input wire reset_n,
  input wire [11:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire local_async_conv_clock,
  input wire clock_module_ref_out,
  input wire cmp_decision,
  output reg [4:0] channel_select,
  output reg [3:0] pin_analog_enable,
  output reg temp_sensor_sel,
  output reg bandgap_sel,
  output reg converter_on,
  output reg [9:0] dac_code,
  output reg sample_hold,
  output reg conv_irq
);
  // Channel decode for pin, temperature sensor and bandgap routing
  function [5:0] sact_route;
    input [4:0] ch;
    input [3:0] pe;
    begin
      sact_route = 6'h00;
      if (ch < 5'h04) begin
        sact_route[3:0] = pe & (4'h1 << ch[1:0]); // RL1
      end
      sact_route[4] = (ch == `SACT_CH_TEMP); // RL3
      sact_route[5] = (ch == `SACT_CH_BGAP);
    end
  endfunction
  // States
  localparam ST_IDLE = 3'b001;
  localparam ST_SMP = 3'b010;
  localparam ST_CONV = 3'b100;
  // Registers
  reg [7:0] ctrl1_q; // Flag, irq enable, continuous, channel
  reg [7:0] ctrl2_q; // Trigger select and compare control
  reg [7:0] cfg_q; // Low power, sample length, mode, clock select
  reg [7:0] pinen_q; // Single pin enable register
  reg [7:0] wake_q; // Wakeup source and rate
  reg [7:0] pwr_q; // Power management bits
  reg [9:0] cmpval_q; // Compare value
  reg [9:0] result_q; // Last result
  reg [2:0] st_q; // Conversion state
  reg [9:0] sar_q; // Approximation register
  reg [3:0] bit_q; // Bit under trial
  reg [3:0] smp_q; // Sample counter
  reg [16:0] div_q; // Conversion clock divider
  reg [16:0] khz_q; // 1 kHz tick generator
  reg [15:0] wcnt_q; // Wakeup counter
  reg armed_q; // Continuous waiting for hardware trigger
  reg [2:0] acs_q; // Async clock synchroniser
  reg [2:0] ref_q; // Reference clock synchroniser
  reg [2:0] cd_q; // Decision synchroniser
  reg aw_q, w_q; // Write channel capture
  reg [11:0] awa_q;
  reg [31:0] wd_q;
  reg [3:0] ws_q; // Captured write strobes
  reg [2:0] stl_q; // Decision settle counter
  // Bus handshake helpers
  wire wr_go = aw_q & w_q & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire wr_c1 = wr_go & (awa_q == `SACT_OFF_CTRL1) & ws_q[0];
  wire rd_res = rd_go & (s_axi_araddr == `SACT_OFF_RESULT);
  // Clock edge events
  wire acs_rise = acs_q[1] & ~acs_q[2];
  wire ref_rise = ref_q[1] & ~ref_q[2];
  wire [1:0] clksel = cfg_q[1:0];
  wire in_stop3 = pwr_q[`SACT_PW_STOP3];
  wire stop_ok = pwr_q[`SACT_PW_LOWVOLT_DETECT_ENABLE] & pwr_q[`SACT_PW_LOWVOLT_DETECT_STOP_ENABLE]; // RL9
  wire run_ok = ~in_stop3 | stop_ok; // RL9
  wire [16:0] div_max = cfg_q[`SACT_CFG_LOWPWR] ? 17'h00003 : 17'h00001;
  wire div_tick = (clksel == 2'b11) ? acs_rise : (div_q == 17'h00000); // RL5
  wire wk_src = wake_q[`SACT_WK_REFSEL] ? ref_rise : (khz_q == 17'h00000);
  wire [15:0] wtop = 16'h0001 << wake_q[2:0]; // RL7
  wire wk_ovf = wk_src & (wcnt_q == wtop - 16'h0001); // RL6 RL8
  wire hwt = ctrl2_q[`SACT_C2_HWTRG];
  wire [4:0] ch = ctrl1_q[4:0];
  wire [5:0] route = sact_route(ch, pinen_q[3:0]); // RL1 RL3
  // Final word with the last decision in place of its trial bit
  wire [9:0] sar_fin = {sar_q[9:1], cd_q[2]}; // RL11
  wire cmp_true = ctrl2_q[`SACT_C2_CMPGE] ? (sar_fin >= cmpval_q) :
                  (sar_fin < cmpval_q); // RL15
  wire start_hw = hwt & wk_ovf & (ch != `SACT_CH_OFF) &
                  ((st_q == ST_IDLE) | armed_q); // RL6 RL17 RL20
  // Synchronisers: three flops, rising edge counted when 2 is high and 3 still low
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      acs_q <= 3'h0;
      ref_q <= 3'h0;
      cd_q <= 3'h0;
    end else begin
      acs_q <= {acs_q[1:0], local_async_conv_clock};
      ref_q <= {ref_q[1:0], clock_module_ref_out};
      cd_q <= {cd_q[1:0], cmp_decision};
    end
  end
  // Conversion clock divider and wakeup counter
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= 17'h00000;
      khz_q <= 17'h00000;
      wcnt_q <= 16'h0000;
    end else begin
      if (div_q == 17'h00000) begin
        div_q <= (clksel == 2'b01) ? div_max + div_max + 17'h00001 : div_max;
      end else begin
        div_q <= div_q - 17'h00001;
      end
      khz_q <= (khz_q == 17'h00000) ? KHZ_DIV[16:0] - 17'h00001 :
               khz_q - 17'h00001; // RL7
      if (wk_src) begin
        wcnt_q <= wk_ovf ? 16'h0000 : wcnt_q + 16'h0001; // RL6
      end
    end
  end
  // AXI4-Lite slave: address and data taken in either order
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'b00;
      s_axi_rdata <= 32'h00000000;
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awa_q <= 12'h000;
      wd_q <= 32'h00000000;
      ws_q <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_q & ~s_axi_awready & s_axi_awvalid;
      s_axi_wready <= ~w_q & ~s_axi_wready & s_axi_wvalid;
      if (s_axi_awvalid & s_axi_awready) begin
        aw_q <= 1'b1;
        awa_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_q <= 1'b1;
        wd_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (awa_q > `SACT_OFF_PWR) ? 2'b10 : 2'b00;
      end else if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= 2'b00;
        case (s_axi_araddr)
          `SACT_OFF_CTRL1: s_axi_rdata <= {24'h0, ctrl1_q};
          `SACT_OFF_CTRL2: s_axi_rdata <= {24'h0,
            (st_q != ST_IDLE) | armed_q, ctrl2_q[6:0]};
          `SACT_OFF_RESULT: s_axi_rdata <= {22'h0, result_q};
          `SACT_OFF_CMPVAL: s_axi_rdata <= {22'h0, cmpval_q};
          `SACT_OFF_CFG: s_axi_rdata <= {24'h0, cfg_q};
          `SACT_OFF_PINEN: s_axi_rdata <= {24'h0, pinen_q};
          `SACT_OFF_WAKE: s_axi_rdata <= {24'h0, wake_q};
          `SACT_OFF_PWR: s_axi_rdata <= {24'h0, pwr_q};
          default: begin
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
  // Register writes (control 1 handled with the converter)
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl2_q <= `SACT_RST_ZERO;
      cfg_q <= `SACT_RST_ZERO;
      pinen_q <= `SACT_RST_ZERO;
      wake_q <= `SACT_RST_ZERO;
      pwr_q <= `SACT_RST_ZERO;
      cmpval_q <= 10'h000;
    end else if (wr_go & ws_q[0]) begin
      case (awa_q)
        `SACT_OFF_CTRL2: ctrl2_q <= {1'b0, wd_q[6:4], 4'h0};
        `SACT_OFF_CFG: cfg_q <= wd_q[7:0]; // RL16
        `SACT_OFF_PINEN: pinen_q <= wd_q[7:0]; // RL10
        `SACT_OFF_WAKE: wake_q <= {4'h0, wd_q[3:0]};
        `SACT_OFF_PWR: pwr_q <= {4'h0, wd_q[3:0]};
        `SACT_OFF_CMPVAL: begin
          cmpval_q <= {ws_q[1] ? wd_q[9:8] : cmpval_q[9:8], wd_q[7:0]};
        end
        default: ;
      endcase
    end
  end
  // Converter sequencer: sample, then one bit per conversion clock once the decision has settled
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl1_q <= `SACT_RST_CTRL1;
      st_q <= ST_IDLE;
      sar_q <= 10'h000;
      bit_q <= 4'h0;
      smp_q <= 4'h0;
      result_q <= 10'h000;
      armed_q <= 1'b0;
      stl_q <= 3'h0;
    end else begin
      stl_q <= (stl_q == 3'h0) ? 3'h0 : stl_q - 3'h1;
      if (rd_res) begin
        ctrl1_q[`SACT_C1_FLAG] <= 1'b0; // RL19
      end
      if (wr_c1) begin
        // Write aborts and restarts unless channel is off or hardware trigger is selected
        ctrl1_q <= {1'b0, wd_q[6:0]}; // RL18 RL19
        armed_q <= 1'b0;
        st_q <= ST_IDLE;
        if (wd_q[4:0] != `SACT_CH_OFF & ~hwt) begin
          st_q <= ST_SMP; // RL18 RL17
          smp_q <= cfg_q[`SACT_CFG_LONGSMP] ? `SACT_SMP_LONG :
                   `SACT_SMP_SHORT; // RL16
        end
      end else if (start_hw & run_ok) begin
        st_q <= ST_SMP; // RL6 RL20
        armed_q <= 1'b0;
        smp_q <= cfg_q[`SACT_CFG_LONGSMP] ? `SACT_SMP_LONG : `SACT_SMP_SHORT;
      end else if (run_ok & div_tick) begin
        case (st_q)
          ST_SMP: begin
            if (smp_q == 4'h0) begin
              st_q <= ST_CONV;
              sar_q <= 10'h200;
              bit_q <= 4'h9;
              stl_q <= `SACT_SETTLE;
            end else begin
              smp_q <= smp_q - 4'h1;
            end
          end
          ST_CONV: if (stl_q == 3'h0) begin // Decision has settled
            // Keep trial bit if input is above the trial level
            sar_q[bit_q] <= cd_q[2]; // RL11
            if (bit_q != 4'h0) begin
              sar_q[bit_q - 4'h1] <= 1'b1; // RL11
              bit_q <= bit_q - 4'h1;
              stl_q <= `SACT_SETTLE;
            end else begin
              if (~ctrl2_q[`SACT_C2_CMPEN] | cmp_true) begin
                result_q <= cfg_q[`SACT_CFG_MODE8] ?
                  {2'b00, sar_fin[9:2]} : sar_fin; // RL12
                ctrl1_q[`SACT_C1_FLAG] <= 1'b1; // RL14 RL19
              end
              st_q <= ST_IDLE; // RL13
              if (ctrl1_q[`SACT_C1_CONT]) begin
                if (hwt) begin
                  armed_q <= 1'b1; // RL20
                end else begin
                  st_q <= ST_SMP; // RL13
                  smp_q <= cfg_q[`SACT_CFG_LONGSMP] ? `SACT_SMP_LONG :
                           `SACT_SMP_SHORT;
                end
              end
            end
          end
          default: ;
        endcase
      end
    end
  end
  // Analog-facing outputs and interrupt, all registered
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      channel_select <= `SACT_CH_OFF;
      pin_analog_enable <= 4'h0;
      temp_sensor_sel <= 1'b0;
      bandgap_sel <= 1'b0;
      converter_on <= 1'b0;
      dac_code <= 10'h000;
      sample_hold <= 1'b0;
      conv_irq <= 1'b0;
    end else begin
      channel_select <= ch; // RL2
      pin_analog_enable <= route[3:0]; // RL1 RL10
      temp_sensor_sel <= route[4]; // RL3
      bandgap_sel <= route[5]; // RL4
      converter_on <= (ch != `SACT_CH_OFF) & run_ok; // RL1 RL9
      dac_code <= sar_q;
      sample_hold <= (st_q == ST_SMP);
      conv_irq <= ctrl1_q[`SACT_C1_FLAG] & ctrl1_q[`SACT_C1_IRQEN]; // RL21
    end
  end
endmodule // sact_ctrl
`default_nettype wire

// >>> hw/sact_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef SACT_REGS_VH
`define SACT_REGS_VH
// Byte offsets on the AXI4-Lite bus
`define SACT_OFF_CTRL1 12'h000
`define SACT_OFF_CTRL2 12'h004
`define SACT_OFF_RESULT 12'h008
`define SACT_OFF_CMPVAL 12'h00C
`define SACT_OFF_CFG 12'h010
`define SACT_OFF_PINEN 12'h014
`define SACT_OFF_WAKE 12'h018
`define SACT_OFF_PWR 12'h01C
// Control 1 fields
`define SACT_C1_FLAG 7
`define SACT_C1_IRQEN 6
`define SACT_C1_CONT 5
// Control 2 fields
`define SACT_C2_ACTIVE 7
`define SACT_C2_HWTRG 6
`define SACT_C2_CMPEN 5
`define SACT_C2_CMPGE 4
// Configuration fields
`define SACT_CFG_LOWPWR 7
`define SACT_CFG_LONGSMP 4
`define SACT_CFG_MODE8 2
// Wakeup counter fields
`define SACT_WK_REFSEL 3
// Power management fields
`define SACT_PW_STOP3 3
`define SACT_PW_LOWVOLT_DETECT_ENABLE 2
`define SACT_PW_LOWVOLT_DETECT_STOP_ENABLE 1
`define SACT_PW_BANDGAP_BUFFER_ENABLE 0
// Reset values
`define SACT_RST_CTRL1 8'h1F
`define SACT_RST_ZERO 8'h00
// Channel codes
`define SACT_CH_OFF 5'h1F
`define SACT_CH_TEMP 5'h1A
`define SACT_CH_BGAP 5'h1B
`define SACT_CH_VREFH 5'h1D
`define SACT_CH_VREFL 5'h1E
// Timing: 1 kHz source at 100 MHz is 100000 cycles per tick
`define SACT_KHZ_HZ 1000
`define SACT_CLK_HZ 100000000
`define SACT_SMP_SHORT 4'h3
`define SACT_SMP_LONG 4'hF
// Cycles for a trial level to pass the decision synchroniser
`define SACT_SETTLE 3'h4
`endif

// >>> tb/sact_analog_model.sv
// Analog source model answering the converter's trial comparisons
`timescale 1ns/1ns
`default_nettype none
module sact_analog_model (
  input wire logic [4:0] channel_select,
  input wire logic [3:0] pin_analog_enable,
  input wire logic temp_sensor_sel,
  input wire logic bandgap_sel,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] pin_level,
  output logic cmp_decision
);
  logic [9:0] level; // Routed source voltage in codes
  // Pick the source that the decode routes to the sampler
  always_comb begin
    level = 10'h000;
    if (pin_analog_enable != 4'h0) begin
      level = pin_level + {8'h00, channel_select[1:0]};
    end else if (temp_sensor_sel) begin
      level = 10'h155;
    end else if (bandgap_sel) begin
      level = 10'h0C8;
    end else if (channel_select == 5'h1D) begin
      level = 10'h3FF;
    end
  end
  // Input sits half a step above level, so codes up to it pass
  assign cmp_decision = (dac_code <= level);
endmodule // sact_analog_model
`default_nettype wire

// >>> tb/sact_ctrl_assertions.sv
// Port-level checker for the converter control block
`timescale 1ns/1ns
`default_nettype none
module sact_ctrl_assertions (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [4:0] channel_select,
  input wire logic [3:0] pin_analog_enable,
  input wire logic temp_sensor_sel,
  input wire logic bandgap_sel,
  input wire logic converter_on
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);
  // Write walk: both taken, response two edges later
  sequence s_wr_take; s_axi_awready && s_axi_wready; endsequence
  sequence s_wr_resp; ##2 s_axi_bvalid; endsequence
  a_write_resp: assert property (s_wr_take |-> s_wr_resp)
    else $error("write response late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_ready_pulse: assert property (s_axi_arready |=> !s_axi_arready)
    else $error("arready held");
  a_pin_route: assert property (pin_analog_enable != 4'h0 |->
    $onehot(pin_analog_enable) && (channel_select < 5'h04 ||
    $past(channel_select) < 5'h04)) else $error("bad pin route");
  a_temp_sel: assert property (temp_sensor_sel |-> channel_select == 5'h1A ||
    $past(channel_select) == 5'h1A) else $error("bad sensor select");
  a_bgap_sel: assert property (bandgap_sel |-> channel_select == 5'h1B ||
    $past(channel_select) == 5'h1B) else $error("bad bandgap select");
  a_off_code: assert property (channel_select == 5'h1F [*2] |-> !converter_on)
    else $error("converter on while off");
endmodule // sact_ctrl_assertions
bind sact_ctrl sact_ctrl_assertions sact_ctrl_assertions_inst (.sys_clk,
  .reset_n, .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .channel_select, .pin_analog_enable, .temp_sensor_sel, .bandgap_sel,
  .converter_on);
`default_nettype wire

// >>> tb/sact_ctrl_tb_top.sv
// Self-checking bench for the converter control block
`timescale 1ns/1ns
`default_nettype none
module sact_ctrl_tb_top;
  logic sys_clk, reset_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, local_async_conv_clock;
  logic clock_module_ref_out, cmp_decision, temp_sensor_sel, bandgap_sel;
  logic converter_on, sample_hold, conv_irq;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb, pin_analog_enable;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [4:0] channel_select;
  logic [9:0] dac_code, pin_level;
  int errors = 0, checks = 0, cyc = 0;
  // Short wakeup tick keeps hardware trigger runs brief
  sact_ctrl #(.KHZ_DIV(10)) sact_ctrl_inst (.sys_clk, .reset_n, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .local_async_conv_clock, .clock_module_ref_out,
    .cmp_decision, .channel_select, .pin_analog_enable, .temp_sensor_sel,
    .bandgap_sel, .converter_on, .dac_code, .sample_hold, .conv_irq);
  sact_analog_model sact_analog_model_inst (.channel_select, .pin_analog_enable,
    .temp_sensor_sel, .bandgap_sel, .dac_code, .pin_level, .cmp_decision);
  // Clocks: bus, unrelated async converter clock, wakeup reference
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    local_async_conv_clock = 1'b0;
    forever #7 local_async_conv_clock = ~local_async_conv_clock;
  end
  initial begin
    clock_module_ref_out = 1'b0;
    forever #23 clock_module_ref_out = ~clock_module_ref_out;
  end
  // Hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (2) @(negedge sys_clk);
  endtask
  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
    settle();
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge sys_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
    settle();
  endtask
  task automatic wirq();
    while (conv_irq !== 1'b1) @(negedge sys_clk);
  endtask
  task automatic t_decode();
    rd(12'h000);
    chk(d, 32'h1F);
    chk(converter_on, 1'b0);
    rd(12'h020);
    chk(r, 2'b10);
    wr(12'h014, 32'h4);
    chk(r, 2'b00);
    wr(12'h020, 32'h0);
    chk(r, 2'b10);
    wr(12'h000, 32'h02);
    chk(pin_analog_enable, 4'h4);
    wr(12'h000, 32'h01);
    chk(pin_analog_enable, 4'h0);
    wr(12'h01C, 32'h01);
    wr(12'h000, 32'h1B);
    chk(bandgap_sel, 1'b1);
    wr(12'h000, 32'h1A);
    chk(temp_sensor_sel, 1'b1);
    wr(12'h000, 32'h00);
    wr(12'h01C, 32'h08);
    chk(converter_on, 1'b0);
    wr(12'h01C, 32'h0E);
    chk(converter_on, 1'b1);
    wr(12'h01C, 32'h00);
    wr(12'h000, 32'h1F);
    chk(converter_on, 1'b0);
  endtask
  // One single conversion on pin 0 per clock source, then 8-bit mode and temperature sensor; result and flag
  task automatic t_convert();
    wr(12'h014, 32'h1);
    for (int i = 0; i < 3; i++) begin
      wr(12'h010, {30'h0, i == 0 ? 2'b00 : i == 1 ? 2'b01 : 2'b11});
      wr(12'h000, 32'h40);
      chk(sample_hold, 1'b1);
      wirq();
      chk(sample_hold, 1'b0);
      chk(dac_code, 32'h2A5);
      rd(12'h000);
      chk(d[7], 1'b1);
      rd(12'h004);
      chk(d[7], 1'b0);
      rd(12'h008);
      chk(d, 32'h2A5);
      chk(conv_irq, 1'b0);
    end
    wr(12'h010, 32'h94);
    wr(12'h000, 32'h40);
    wirq();
    rd(12'h008);
    chk(d, 32'hA9);
    wr(12'h010, 32'h00);
    wr(12'h000, 32'h5A);
    wirq();
    rd(12'h008);
    chk(d, 32'h155);
  endtask
  task automatic t_cont_cmp();
    wr(12'h000, 32'h60);
    wirq();
    rd(12'h008);
    wirq();
    rd(12'h008);
    chk(d, 32'h2A5);
    wr(12'h000, 32'h1F);
    wr(12'h00C, 32'h300);
    wr(12'h004, 32'h30);
    wr(12'h000, 32'h40);
    repeat (200) @(negedge sys_clk);
    chk(conv_irq, 1'b0);
    wr(12'h004, 32'h20);
    wr(12'h000, 32'h40);
    wirq();
    rd(12'h008);
    chk(d, 32'h2A5);
  endtask
  task automatic t_hwtrig();
    wr(12'h018, 32'h00);
    wr(12'h004, 32'h40);
    wr(12'h000, 32'h40);
    wirq();
    rd(12'h008);
    chk(d, 32'h2A5);
    wr(12'h018, 32'h08);
    wr(12'h000, 32'h60);
    wirq();
    rd(12'h008);
    wirq();
    rd(12'h008);
    chk(d, 32'h2A5);
    wr(12'h000, 32'h1F);
  endtask
  task automatic summarize();
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Reset, then scenarios
  initial begin
    reset_n = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
    {s_axi_arvalid, s_axi_rready} = 2'b00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    pin_level = 10'h2A5;
    repeat (10) @(posedge sys_clk);
    reset_n <= 1'b1;
    t_decode();
    t_convert();
    t_cont_cmp();
    t_hwtrig();
    summarize();
  end
endmodule // sact_ctrl_tb_top
`default_nettype wire
